// file: core/ssc_burst_ctr.sv
`timescale 1ns/1ps
module ssc_burst_ctr
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // control
  input  wire logic       load_in,
  input  wire logic       advance_in,
  input  wire logic       interleave_in,
  input  wire logic [1:0] preset_in,
  // offsets
  output logic      [1:0] offset_out,
  output logic      [1:0] next_offset_out
);
  logic [1:0] preset;
  logic [1:0] step;
  logic [1:0] next_step;

  assign next_step  = 2'(step + 2'h1);
  assign offset_out = burst_offset(preset, step, interleave_in);

  always_comb begin
    if (load_in) begin
      next_offset_out = preset_in;
    end else if (advance_in) begin
      next_offset_out = burst_offset(preset, next_step, interleave_in);
    end else begin
      next_offset_out = offset_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      preset <= STEP_RST;
      step   <= STEP_RST;
    end else if (load_in) begin
      preset <= preset_in;
      step   <= STEP_RST;
    end else if (advance_in) begin
      step   <= next_step;
    end
  end
endmodule

// file: core/ssc_byte_wr.sv
`timescale 1ns/1ps
module ssc_byte_wr #(
  parameter int LANES = 8
) (
  // write controls
  input  wire logic             global_write_n_in,
  input  wire logic             byte_write_gate_n_in,
  input  wire logic [LANES-1:0] lane_write_n_in,
  // decode
  output logic                  is_write_out,
  output logic      [LANES-1:0] lane_we_out
);
  always_comb begin
    if (!global_write_n_in) begin
      lane_we_out  = '1;
      is_write_out = 1'b1;
    end else if (!byte_write_gate_n_in) begin
      lane_we_out  = ~lane_write_n_in;
      is_write_out = 1'b1;
    end else begin
      lane_we_out  = '0;
      is_write_out = 1'b0;
    end
  end
endmodule

// file: core/ssc_sram_ctrl.sv
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
module ssc_sram_ctrl
  import ssc_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF,
  parameter int LANE_W = LANE_W_DEF
) (
  // clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    sys_rst_in,
  // address
  input  wire logic [ADDR_W-3:0]       addr_hi_in,
  input  wire logic                    addr_bit0_in,
  input  wire logic                    addr_bit1_in,
  // chip selects and burst control
  input  wire logic                    chip_sel_n_first_in,
  input  wire logic                    chip_sel_pos_in,
  input  wire logic                    chip_sel_n_third_in,
  input  wire logic                    addr_strobe_proc_n_in,
  input  wire logic                    addr_strobe_ctrl_n_in,
  input  wire logic                    burst_advance_n_in,
  // write controls
  input  wire logic                    global_write_n_in,
  input  wire logic                    byte_write_gate_n_in,
  input  wire logic [LANES-1:0]        lane_write_n_in,
  input  wire logic                    out_enable_n_in,
  // mode pins
  input  wire logic                    sleep_req_in,
  input  wire logic                    flowthrough_sel_n_in,
  input  wire logic                    linear_order_n_in,
  input  wire logic                    deselect_mode_sel_in,
  input  wire logic                    drive_strength_sel_in,
  // data lanes
  input  wire logic [LANES*LANE_W-1:0] data_in,
  output logic      [LANES*LANE_W-1:0] data_out,
  output logic      [LANES-1:0]        data_oe_n_out,
  output logic                         drive_high_out,
  // wishbone slave
  input  wire logic                    wb_cyc_in,
  input  wire logic                    wb_stb_in,
  input  wire logic                    wb_we_in,
  input  wire logic [3:0]              wb_adr_in,
  input  wire logic [3:0]              wb_sel_in,
  input  wire logic [31:0]             wb_dat_in,
  output logic      [31:0]             wb_dat_out,
  output logic                         wb_ack_out
);
  localparam int DATA_W = LANES * LANE_W;

  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

  logic              mode_pipe;
  logic              mode_single;
  logic              mode_intlv;
  logic              mode_drvlo;
  logic              pin_sleep;
  logic [31:0]       ctrl;
  logic              standby;
  logic              selected;
  logic              start_proc;
  logic              start_ctrl;
  logic              strobe;
  logic              begin_burst;
  logic              deselect;
  logic              cont_burst;
  logic              access;
  logic              wr_op;
  logic              is_write;
  logic [LANES-1:0]  lane_we;
  logic [1:0]        offset;
  logic [1:0]        next_offset;
  logic [ADDR_W-3:0] addr_hi;
  logic [ADDR_W-1:0] cur_addr;
  logic              active;
  logic              rd1;
  logic              rd2;
  logic              wr1;
  logic              desel1;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] pipe_data;
  logic              drive;

  // mode straps, defaults loaded while in reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mode_pipe   <= PIPE_OPEN;
      mode_single <= SINGLE_OPEN;
      mode_drvlo  <= DRVLO_OPEN;
      pin_sleep   <= SLEEP_OPEN;
      mode_intlv  <= INTLV_RST;
    end else begin
      mode_pipe   <= flowthrough_sel_n_in;
      mode_single <= deselect_mode_sel_in;
      mode_drvlo  <= drive_strength_sel_in;
      pin_sleep   <= sleep_req_in;
      mode_intlv  <= linear_order_n_in;
    end
  end

  assign drive_high_out = ~mode_drvlo;
  assign standby        = sleep_req_in | pin_sleep | ctrl[CTRL_SLEEP_BIT];

  // cycle decode
  assign selected    = ~chip_sel_n_first_in & chip_sel_pos_in
                       & ~chip_sel_n_third_in;
  assign start_proc  = ~addr_strobe_proc_n_in & ~chip_sel_n_first_in;
  assign start_ctrl  = ~addr_strobe_ctrl_n_in & ~start_proc;
  assign strobe      = (start_proc | start_ctrl) & ~standby;
  assign begin_burst = strobe & selected;
  assign deselect    = strobe & ~selected;
  assign cont_burst  = ~strobe & active & ~standby;
  assign access      = begin_burst | cont_burst;
  assign wr_op       = access & is_write & ~start_proc;

  ssc_byte_wr #(
    .LANES (LANES)
  ) u_byte_wr (
    .global_write_n_in    (global_write_n_in),
    .byte_write_gate_n_in (byte_write_gate_n_in),
    .lane_write_n_in      (lane_write_n_in),
    .is_write_out         (is_write),
    .lane_we_out          (lane_we)
  );

  ssc_burst_ctr u_burst_ctr (
    .sys_clk_in      (sys_clk_in),
    .sys_rst_in      (sys_rst_in),
    .load_in         (begin_burst),
    .advance_in      (cont_burst & ~burst_advance_n_in),
    .interleave_in   (mode_intlv),
    .preset_in       ({addr_bit1_in, addr_bit0_in}),
    .offset_out      (offset),
    .next_offset_out (next_offset)
  );

  assign cur_addr = begin_burst ? {addr_hi_in, addr_bit1_in, addr_bit0_in}
                                : {addr_hi, next_offset};

  // burst state
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      active  <= 1'b0;
      addr_hi <= '0;
    end else if (begin_burst) begin
      active  <= 1'b1;
      addr_hi <= addr_hi_in;
    end else if (deselect) begin
      active  <= 1'b0;
    end
  end

  // array write per lane
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_op && lane_we[i]) begin
        mem[cur_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
      end
    end
  end

  // array read, first stage
  always_ff @(posedge sys_clk_in) begin
    if (access && !wr_op) begin
      rd_data <= mem[cur_addr];
    end
  end

  // output register stage
  always_ff @(posedge sys_clk_in) begin
    pipe_data <= rd_data;
  end

  // output stage flags
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rd1    <= 1'b0;
      rd2    <= 1'b0;
      wr1    <= 1'b0;
      desel1 <= 1'b0;
    end else begin
      rd1    <= access & ~wr_op;
      rd2    <= rd1;
      wr1    <= wr_op;
      desel1 <= deselect | standby;
    end
  end

  always_comb begin
    if (mode_pipe) begin
      drive = mode_single ? (rd2 & ~desel1) : rd2;
    end else begin
      drive = mode_single ? rd1 : (rd1 | (rd2 & desel1));
    end
  end

  assign data_out      = mode_pipe ? pipe_data : rd_data;
  assign data_oe_n_out = {LANES{~(drive & ~wr1 & ~standby & ~out_enable_n_in)}};

  // wishbone registers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ctrl <= CTRL_RST;
    end else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
                 && wb_adr_in == CTRL_OFS && wb_sel_in[0]) begin
      ctrl <= {31'h0, wb_dat_in[CTRL_SLEEP_BIT]};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      wb_dat_out <= 32'h0;
      if (wb_cyc_in && wb_stb_in && !wb_we_in) begin
        if (wb_adr_in == CTRL_OFS) begin
          wb_dat_out <= ctrl;
        end else if (wb_adr_in == STATUS_OFS) begin
          wb_dat_out[ST_ACTIVE_BIT]            <= active;
          wb_dat_out[ST_SLEEP_BIT]             <= standby;
          wb_dat_out[ST_PIPE_BIT]              <= mode_pipe;
          wb_dat_out[ST_SINGLE_BIT]            <= mode_single;
          wb_dat_out[ST_INTLV_BIT]             <= mode_intlv;
          wb_dat_out[ST_DRVLO_BIT]             <= mode_drvlo;
          wb_dat_out[ST_OFS_LSB +: 2]          <= offset;
        end
      end
    end
  end
endmodule

// file: inc/ssc_pkg.sv
package ssc_pkg;
  // memory shape
  localparam int ADDR_W_DEF  = 19;
  localparam int LANES_DEF   = 8;
  localparam int LANE_W_DEF  = 9;
  // register bus map
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  // status field positions
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_SLEEP_BIT  = 1;
  localparam int ST_PIPE_BIT   = 2;
  localparam int ST_SINGLE_BIT = 3;
  localparam int ST_INTLV_BIT  = 4;
  localparam int ST_DRVLO_BIT  = 5;
  localparam int ST_OFS_LSB    = 8;
  // mode pin levels taken when a pin is left open
  localparam logic PIPE_OPEN   = 1'b1;
  localparam logic SINGLE_OPEN = 1'b1;
  localparam logic DRVLO_OPEN  = 1'b1;
  localparam logic SLEEP_OPEN  = 1'b0;
  // burst order after reset: linear
  localparam logic INTLV_RST   = 1'b0;
  localparam logic [1:0] STEP_RST = 2'h0;

  // burst offset for a preset and step count
  function automatic logic [1:0] burst_offset(input logic [1:0] preset,
                                              input logic [1:0] step,
                                              input logic       interleave);
    burst_offset = interleave ? (preset ^ step) : 2'(preset + step);
  endfunction
endpackage

// file: verif/ssc_host_model.sv
`timescale 1ns/1ps
module ssc_host_model #(
  parameter int ADDR_W = 6
) (
  // bus clock
  input  wire logic              clk_in,
  // controller pins
  output logic      [ADDR_W-1:0] addr_out,
  output logic                   chip_sel_n_first_out,
  output logic                   chip_sel_pos_out,
  output logic                   chip_sel_n_third_out,
  output logic                   addr_strobe_proc_n_out,
  output logic                   addr_strobe_ctrl_n_out,
  output logic                   burst_advance_n_out,
  output logic                   global_write_n_out,
  output logic                   byte_write_gate_n_out,
  output logic      [7:0]        lane_write_n_out,
  output logic                   out_enable_n_out,
  output logic      [71:0]       data_out
);
  initial begin
    {chip_sel_n_first_out, chip_sel_n_third_out, addr_strobe_proc_n_out} = '1;
    {addr_strobe_ctrl_n_out, burst_advance_n_out, global_write_n_out} = '1;
    {byte_write_gate_n_out, lane_write_n_out, out_enable_n_out} = '1;
    {chip_sel_pos_out, addr_out, data_out} = '0;
  end
  // k: 0 hold, 1 advance, 2/3 read by ctrl/proc strobe, 4/5 global/byte write, 6 deselect
  task automatic op(input int k, input logic [ADDR_W-1:0] a, input logic [7:0] ln,
                    input logic [71:0] d, input logic g);
    @(posedge clk_in);
    addr_out <= a;
    chip_sel_n_first_out <= 1'b0;
    chip_sel_n_third_out <= 1'b0;
    chip_sel_pos_out <= (k != 6);
    addr_strobe_proc_n_out <= (k != 3);
    addr_strobe_ctrl_n_out <= !(k inside {2, 4, 5, 6});
    burst_advance_n_out <= (k != 1);
    global_write_n_out <= (k != 4);
    byte_write_gate_n_out <= (k != 5);
    lane_write_n_out <= ln;
    out_enable_n_out <= g;
    data_out <= (k inside {4, 5}) ? d : ~data_out;
  endtask
endmodule

// file: verif/ssc_sram_chk.sv
`timescale 1ns/1ps
module ssc_sram_chk #(
  parameter int LANES = 8
) (
  // clock, reset and bus pins
  input wire logic             sys_clk_in,
  input wire logic             sys_rst_in,
  input wire logic             chip_sel_n_first_in,
  input wire logic             chip_sel_pos_in,
  input wire logic             chip_sel_n_third_in,
  input wire logic             addr_strobe_proc_n_in,
  input wire logic             addr_strobe_ctrl_n_in,
  input wire logic             global_write_n_in,
  input wire logic             byte_write_gate_n_in,
  input wire logic             out_enable_n_in,
  input wire logic             sleep_req_in,
  input wire logic             deselect_mode_sel_in,
  // watched outputs
  input wire logic [LANES-1:0] data_oe_n_out,
  input wire logic             drive_high_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic sel, wr, take, rd, desel;
  assign sel = !chip_sel_n_first_in && chip_sel_pos_in && !chip_sel_n_third_in;
  assign wr = (addr_strobe_proc_n_in || chip_sel_n_first_in)
              && !(global_write_n_in && byte_write_gate_n_in);
  assign take = !sleep_req_in && (!addr_strobe_ctrl_n_in
                || (!addr_strobe_proc_n_in && !chip_sel_n_first_in));
  assign rd = take && sel && !wr;
  assign desel = take && !sel;
  chk_write_undriven: assert property (take && sel && wr |=> &data_oe_n_out)
    else $error("lanes driven after a write");
  chk_oe_gates: assert property (out_enable_n_in |-> &data_oe_n_out)
    else $error("lanes driven with enable high");
  chk_lanes_alike: assert property (data_oe_n_out == '0 || &data_oe_n_out)
    else $error("lanes enabled unevenly");
  chk_sleep_quiet: assert property (sleep_req_in [*2] |-> &data_oe_n_out)
    else $error("lanes driven in standby");
  chk_read_drives: assert property (rd ##1 !sleep_req_in && !(take && !rd)
    ##1 !out_enable_n_in && !sleep_req_in |-> data_oe_n_out == '0)
    else $error("read data not driven");
  chk_single_off: assert property (desel && deselect_mode_sel_in
    && $past(deselect_mode_sel_in) |=> &data_oe_n_out)
    else $error("single deselect left lanes on");
  chk_dual_hold: assert property (rd ##1 desel && !deselect_mode_sel_in
    && !$past(deselect_mode_sel_in) ##1 !out_enable_n_in |-> data_oe_n_out == '0)
    else $error("dual deselect cut lanes early");
  chk_drive_default: assert property ($fell(sys_rst_in) |-> !drive_high_out)
    else $error("drive strength not at default");
  cov_read: cover property (rd ##2 data_oe_n_out == '0);
  cov_write: cover property (take && sel && wr);
  cov_deselect: cover property (desel);
endmodule

// file: verif/tb_sync_burst_sram_control.sv
`timescale 1ns/1ps
module tb_sync_burst_sram_control;
  import ssc_pkg::*;
  localparam int IDLE = 0, NXT = 1, RDC = 2, RDP = 3, WGW = 4, WBW = 5, DSL = 6;
  logic sys_clk_in, sys_rst_in, addr_bit0_in, addr_bit1_in, drive_high_out;
  logic chip_sel_n_first_in, chip_sel_pos_in, chip_sel_n_third_in, burst_advance_n_in;
  logic addr_strobe_proc_n_in, addr_strobe_ctrl_n_in, global_write_n_in;
  logic byte_write_gate_n_in, out_enable_n_in, sleep_req_in, flowthrough_sel_n_in;
  logic linear_order_n_in, deselect_mode_sel_in, drive_strength_sel_in;
  logic wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [3:0]  addr_hi_in, wb_adr_in, wb_sel_in;
  logic [5:0]  ha;
  logic [7:0]  lane_write_n_in, data_oe_n_out;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic [71:0] data_in, data_out;
  int          mismatches, checks_done;
  assign {addr_hi_in, addr_bit1_in, addr_bit0_in} = ha;
  ssc_sram_ctrl #(.ADDR_W(6)) dut (.*);
  ssc_host_model #(.ADDR_W(6)) host (.clk_in(sys_clk_in), .addr_out(ha),
    .chip_sel_n_first_out(chip_sel_n_first_in), .chip_sel_pos_out(chip_sel_pos_in),
    .chip_sel_n_third_out(chip_sel_n_third_in), .burst_advance_n_out(burst_advance_n_in),
    .addr_strobe_proc_n_out(addr_strobe_proc_n_in), .data_out(data_in),
    .addr_strobe_ctrl_n_out(addr_strobe_ctrl_n_in), .out_enable_n_out(out_enable_n_in),
    .global_write_n_out(global_write_n_in), .byte_write_gate_n_out(byte_write_gate_n_in),
    .lane_write_n_out(lane_write_n_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [71:0] g, input logic [71:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic step(input int k, input logic [5:0] a = '0, input logic [7:0] ln = 8'hff,
                      input logic [71:0] d = '0, input logic g = 1'b0);
    host.op(k, a, ln, d, g);
    @(negedge sys_clk_in);
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    r = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  function automatic logic [71:0] pat(input int o);
    for (int i = 0; i < 8; i++)
      pat[i*9 +: 9] = 9'(o * 16 + i + 1);
  endfunction
  task automatic burst(input int k, input logic [1:0] p, input logic il);
    logic [1:0] o;
    for (int i = 0; i < 8; i++) begin
      step(i == 0 ? k : i < 5 ? NXT : IDLE, {4'h5, p}, 8'hff, '0, il && i < 3);
      o = il ? p ^ 2'(i < 6 ? i - 2 : 4) : p + 2'(i < 6 ? i - 2 : 4);
      if (i >= 2 && !(il && i < 3)) begin
        chk(data_out, pat(o));
      end
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    logic [31:0] r;
    {sys_rst_in, flowthrough_sel_n_in, deselect_mode_sel_in, drive_strength_sel_in} = '1;
    {sleep_req_in, linear_order_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in} = '0;
    {wb_dat_in, mismatches, checks_done} = '0;
    wb_sel_in = 4'hf;
    repeat (6) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    wb(0, CTRL_OFS, '0, r);
    chk(72'(r), 72'(CTRL_RST));
    wb(0, STATUS_OFS, '0, r);
    chk(72'(r), 72'h2c);
    wb(1, 4'h8, '1, r);
    wb(0, 4'h8, '0, r);
    chk(72'(r), 72'h0);
    @(posedge sys_clk_in) drive_strength_sel_in <= 1'b0;
    repeat (2) step(IDLE);
    chk(72'(drive_high_out), 72'h1);
    $display("test modes done");
    for (int o = 0; o < 4; o++)
      step(WGW, {4'h5, 2'(o)}, 8'hff, pat(o));
    burst(RDC, 2'd1, 1'b0);
    @(posedge sys_clk_in) linear_order_n_in <= 1'b1;
    burst(RDP, 2'd2, 1'b1);
    $display("test bursts done");
    step(WGW, 6'h2a, 8'hff, '1);
    step(WBW, 6'h2a, 8'h5a, '0);
    step(WBW, 6'h2a, 8'hff, '0);
    @(posedge sys_clk_in) sleep_req_in <= 1'b1;
    repeat (2) step(IDLE);
    step(WGW, 6'h2a, 8'hff, '0);
    @(posedge sys_clk_in) sleep_req_in <= 1'b0;
    repeat (2) step(IDLE);
    step(RDP, 6'h2a, 8'h00);
    repeat (2) step(IDLE);
    chk(data_out, {9'h0, 9'h1ff, 9'h0, 9'h1ff, 9'h1ff, 9'h0, 9'h1ff, 9'h0});
    $display("test byte writes done");
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk_in);
      deselect_mode_sel_in <= 1'(m);
      flowthrough_sel_n_in <= !m[1];
      step(RDC, 6'h14 + 6'(m));
      step(DSL);
      if (m[1]) chk(data_out, pat(m));
      step(IDLE);
      chk(72'(data_oe_n_out), 72'({8{1'(m)}}));
      step(IDLE);
      chk(72'(data_oe_n_out), 72'hff);
    end
    wb(1, CTRL_OFS, 32'h1, r);
    wb(0, STATUS_OFS, '0, r);
    chk(72'(r[1]), 72'h1);
    chk(72'(r[3:2]), 72'h2);
    wb(1, CTRL_OFS, '0, r);
    $display("test deselect and standby done");
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    mismatches++;
    wrap_up();
  end
endmodule
bind ssc_sram_ctrl ssc_sram_chk #(.LANES(LANES)) u_chk (.*);
